// ### verilog/secp_pkg.sv
// constants and types for the serial memory command port
package secp_pkg;
	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_MEM_RD = 8'h03;
	localparam logic [7:0] OP_MEM_WR = 8'h02;
	// ----------------------------------------
	// status byte layout
	// ----------------------------------------
	localparam int SB_BUSY = 0;
	localparam int SB_LATCH = 1;
	localparam int SB_BP0 = 2;
	localparam int SB_BP1 = 3;
	localparam int SB_LOCK = 4;
	localparam int SB_IDPG = 6;
	localparam int SB_PPEN = 7;
	localparam logic [7:0] STAT_WR_MASK = 8'hDC;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] STAT_BUSY_BYTE = 8'hFF;
	// ----------------------------------------
	// address and protection
	// ----------------------------------------
	localparam int ADDR_W = 15;
	localparam int PAGE_W = 6;
	localparam logic [14:0] PROT_QUARTER = 15'h6000;
	localparam logic [14:0] PROT_HALF = 15'h4000;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_FULL = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_KHZ = 40000;
	localparam int T_WC_US = 5000;
	localparam int WC_CYCLES_DEF = T_WC_US * CLK_KHZ / 1000;
	localparam int WC_W = 18;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_OP = 3'b001,
		S_ADDR = 3'b010,
		S_RDAT = 3'b011,
		S_WDAT = 3'b100,
		S_SOUT = 3'b101,
		S_SIN = 3'b110,
		S_IGN = 3'b111
	} secp_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic commit;
		logic id_page;
		logic [14:0] addr;
		logic [7:0] data;
	} secp_mem_req_t;
endpackage : secp_pkg

// ### verilog/secp_top.sv
// serial command front end: pins, opcode decode, status and write timer
// Notes on behaviour
// - only clock modes (0,0) and (1,1); idle level of sck is free.
// - input bits are captured on rising sck edges.
// - output bits change on falling sck edges during reads.
// - select high: output released, standby unless write cycle runs.
// - write-protect pin high never blocks any write.
// - pin low with pin-enable bit set refuses status writes.
// - pause low freezes the serial state; high resumes without restart.
// - first eight bits after select falls form the opcode.
// - only six opcodes act; others ignored until select rises.
// - set latch 06h, clear latch 04h, status read 05h.
// - status write 01h, memory read 03h, memory write 02h.
// - memory writes need the write latch set, else rejected.
// - 64-byte id page replaces array while page-select bit is 1.
// - lock bit protects id page against writing.
// - write cycle starts at select rise, lasts at most 5 ms.
// - set-latch opcode sets, clear-latch clears the write latch.
// - during write cycle only status read is accepted.
// - busy reads 1 during write cycle, host cannot write it.
// - only low 15 address bits are used.
`timescale 1ns/1ps
module secp_top #(
	parameter int WC_CYCLES = secp_pkg::WC_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic cs_b,
	input wire logic si,
	input wire logic wp_b,
	input wire logic hold_b,
	output logic so_o,
	output logic so_oe,
	output logic standby,
	output logic [7:0] status_o,
	output secp_pkg::secp_mem_req_t mem_req_o,
	input wire logic [7:0] mem_rd_data
);
	import secp_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic prot_hit(input logic [14:0] a, input logic [1:0] bp);
		logic hit;
		hit = 1'b0;
		case (bp)
			BP_NONE: hit = 1'b0;
			BP_QUARTER: hit = (a >= PROT_QUARTER);
			BP_HALF: hit = (a >= PROT_HALF);
			default: hit = 1'b1;
		endcase
		return hit;
	endfunction : prot_hit

	// id page uses only the in-page offset
	function automatic logic [14:0] map_addr(input logic [15:0] a, input logic id);
		return id ? {{(ADDR_W - PAGE_W){1'b0}}, a[PAGE_W-1:0]} : a[ADDR_W-1:0];
	endfunction : map_addr

	function automatic secp_state_t decode_op(input logic [7:0] op, input logic busy);
		secp_state_t s;
		s = S_IGN;
		if (op == OP_STAT_RD) begin
			s = S_SOUT;
		end else if (busy) begin
			s = S_IGN;
		end else begin
			case (op)
				OP_STAT_WR: s = S_SIN;
				OP_MEM_RD: s = S_ADDR;
				OP_MEM_WR: s = S_ADDR;
				default: s = S_IGN;
			endcase
		end
		return s;
	endfunction : decode_op

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic sck_q_r;
	logic cs_q_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_r <= 5'h1B;
			sync2_r <= 5'h1B;
			sck_q_r <= 1'b0;
			cs_q_r <= 1'b1;
		end else begin
			sync1_r <= {sck, cs_b, si, hold_b, wp_b};
			sync2_r <= sync1_r;
			sck_q_r <= sync2_r[4];
			cs_q_r <= sync2_r[3];
		end
	end

	wire sck_s = sync2_r[4];
	wire cs_s = sync2_r[3];
	wire si_s = sync2_r[2];
	wire hold_s = sync2_r[1];
	wire wp_s = sync2_r[0];

	// ----------------------------------------
	// edge and decode wires
	// ----------------------------------------
	secp_state_t state_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] in_sh_r;
	logic [7:0] out_sh_r;
	logic so_r;
	logic [15:0] addr_r;
	logic addr_hi_r;
	logic op_rd_r;
	logic [7:0] stat_r;
	logic busy_r;
	logic [WC_W-1:0] wc_cnt_r;
	logic wr_any_r;
	logic stat_got_r;
	logic set_pend_r;
	logic clr_pend_r;
	logic load_pend_r;
	secp_mem_req_t req_r;

	// mode-neutral: edges, not levels, drive the engine
	// paused: sck edges are not seen
	wire sck_rise = sck_s & ~sck_q_r & ~cs_s & hold_s;
	wire sck_fall = ~sck_s & sck_q_r & ~cs_s & hold_s;
	wire cs_fall = ~cs_s & cs_q_r;
	wire cs_rise = cs_s & ~cs_q_r;
	wire [7:0] byte_in = {in_sh_r[6:0], si_s};
	wire byte_end = sck_rise & (bit_cnt_r == BIT_LAST);
	wire id_pg = stat_r[SB_IDPG];
	wire [1:0] bp = {stat_r[SB_BP1], stat_r[SB_BP0]};
	// pin high never blocks; low with enable bit refuses
	wire hw_prot = stat_r[SB_PPEN] & ~wp_s;
	// busy comes from the timer only
	wire [7:0] stat_view = busy_r ? STAT_BUSY_BYTE : {stat_r[7:1], busy_r};
	wire [15:0] addr_full = {addr_r[7:0], byte_in};
	wire [15:0] addr_pg_inc = {addr_r[15:PAGE_W], addr_r[PAGE_W-1:0] + 6'h01};
	wire [15:0] addr_all_inc = addr_r + 16'h0001;
	wire [15:0] rd_next = id_pg ? addr_pg_inc : addr_all_inc;
	wire [14:0] wr_addr = map_addr(addr_r, id_pg);
	// latch required; id page lock and full protection
	wire wr_block = ~stat_r[SB_LATCH] | prot_hit(wr_addr, bp)
		| (id_pg & (stat_r[SB_LOCK] | (bp == BP_FULL)));
	wire rd_first = byte_end & (state_r == S_ADDR) & addr_hi_r & op_rd_r;
	wire rd_more = byte_end & (state_r == S_RDAT);
	wire rd_go = rd_first | rd_more;
	wire [14:0] rd_addr = rd_first ? map_addr(addr_full, id_pg) : map_addr(rd_next, id_pg);
	wire wr_go = byte_end & (state_r == S_WDAT) & ~wr_block;
	// commit only at a byte boundary on select rise
	wire commit_go = cs_rise & (state_r == S_WDAT) & (bit_cnt_r == 3'h0) & wr_any_r;
	// status write refused under pin protection
	wire stat_commit = cs_rise & (state_r == S_SIN) & (bit_cnt_r == 3'h0) & stat_got_r
		& stat_r[SB_LATCH] & ~hw_prot;
	wire both_id = in_sh_r[SB_IDPG] & in_sh_r[SB_LOCK];
	wire [7:0] wr_mask = both_id ? (STAT_WR_MASK & ~8'h50) : STAT_WR_MASK;
	wire [7:0] stat_new = (stat_r & ~wr_mask) | (in_sh_r & wr_mask);
	wire wc_done = busy_r & (wc_cnt_r == '0);
	wire stat_load = (byte_end & (state_r == S_OP) & (byte_in == OP_STAT_RD))
		| (byte_end & (state_r == S_SOUT));
	wire op_latch = byte_end & (state_r == S_OP) & ~busy_r;

	// ----------------------------------------
	// serial engine
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
			bit_cnt_r <= 3'h0;
			in_sh_r <= 8'h00;
			addr_r <= 16'h0000;
			addr_hi_r <= 1'b0;
			op_rd_r <= 1'b0;
		end else if (cs_s) begin
			state_r <= S_IDLE;
			bit_cnt_r <= 3'h0;
			addr_hi_r <= 1'b0;
		end else if (cs_fall) begin
			state_r <= S_OP;
			bit_cnt_r <= 3'h0;
		end else if (sck_rise) begin
			in_sh_r <= byte_in;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == BIT_LAST) begin
				case (state_r)
					S_OP: begin
						state_r <= decode_op(byte_in, busy_r);
						op_rd_r <= (byte_in == OP_MEM_RD);
					end
					S_ADDR: begin
						addr_r <= addr_full;
						addr_hi_r <= 1'b1;
						if (addr_hi_r) begin
							state_r <= op_rd_r ? S_RDAT : S_WDAT;
						end
					end
					S_RDAT: addr_r <= rd_next;
					// page roll-over keeps the page address
					S_WDAT: addr_r <= addr_pg_inc;
					default: state_r <= state_r;
				endcase
			end
		end
	end

	// ----------------------------------------
	// output shifter
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_sh_r <= 8'h00;
			so_r <= 1'b0;
			load_pend_r <= 1'b0;
		end else begin
			// read data lands one cycle after the request
			load_pend_r <= rd_go;
			if (load_pend_r) begin
				out_sh_r <= mem_rd_data;
			end else if (stat_load) begin
				out_sh_r <= stat_view;
			end else if (sck_fall & ((state_r == S_RDAT) | (state_r == S_SOUT))) begin
				so_r <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// memory requests
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_r <= '0;
			wr_any_r <= 1'b0;
		end else begin
			req_r.rd <= rd_go;
			req_r.wr <= wr_go;
			req_r.commit <= commit_go;
			if (rd_go | wr_go) begin
				req_r.addr <= rd_go ? rd_addr : wr_addr;
				req_r.data <= byte_in;
				req_r.id_page <= id_pg;
			end
			if (cs_fall) begin
				wr_any_r <= 1'b0;
			end else if (wr_go) begin
				wr_any_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// status and write cycle timer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_r <= STAT_RST;
			busy_r <= 1'b0;
			wc_cnt_r <= '0;
			stat_got_r <= 1'b0;
			set_pend_r <= 1'b0;
			clr_pend_r <= 1'b0;
		end else begin
			if (cs_fall) begin
				stat_got_r <= 1'b0;
				set_pend_r <= 1'b0;
				clr_pend_r <= 1'b0;
			end else if (op_latch) begin
				set_pend_r <= (byte_in == OP_SET_LATCH);
				clr_pend_r <= (byte_in == OP_CLR_LATCH);
			end else if (byte_end & (state_r == S_SIN)) begin
				stat_got_r <= 1'b1;
			end else if (sck_rise) begin
				// stray bits after a latch opcode void it
				set_pend_r <= 1'b0;
				clr_pend_r <= 1'b0;
			end
			if (commit_go | stat_commit) begin
				busy_r <= 1'b1;
				wc_cnt_r <= WC_W'(WC_CYCLES - 1);
			end else if (wc_done) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				wc_cnt_r <= wc_cnt_r - 1'b1;
			end
			if (stat_commit) begin
				stat_r <= stat_new;
			end else if (wc_done) begin
				// write disable once the cycle ends
				stat_r[SB_LATCH] <= 1'b0;
			end else if (cs_rise & set_pend_r) begin
				stat_r[SB_LATCH] <= 1'b1;
			end else if (cs_rise & clr_pend_r) begin
				stat_r[SB_LATCH] <= 1'b0;
			end else if (cs_rise & ((state_r == S_RDAT) | (state_r == S_WDAT))) begin
				// id page select drops after an access
				stat_r[SB_IDPG] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// released outside data phases and while paused
	assign so_oe = ~cs_s & hold_s & ((state_r == S_RDAT) | (state_r == S_SOUT));
	assign so_o = so_r;
	// standby only when no cycle is running
	assign standby = cs_s & ~busy_r;
	assign status_o = {stat_r[7:1], busy_r};
	assign mem_req_o = req_r;
endmodule : secp_top

// ### sim/secp_top_assertions.sv
// concurrent checks on the command port pins
`timescale 1ns/1ps
module secp_top_assertions
	import secp_pkg::*;
#(
	parameter int WC_CYCLES = secp_pkg::WC_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic cs_b,
	input wire logic si,
	input wire logic wp_b,
	input wire logic hold_b,
	input wire logic so_o,
	input wire logic so_oe,
	input wire logic standby,
	input wire logic [7:0] status_o,
	input wire secp_pkg::secp_mem_req_t mem_req_o,
	input wire logic [7:0] mem_rd_data
);
	logic [WC_W-1:0] busy_cnt_r;
	wire logic busy = status_o[SB_BUSY];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// counter, since the write cycle is far too long for a repetition
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt_r <= '0;
		end else if (busy) begin
			busy_cnt_r <= busy_cnt_r + 1'b1;
		end else begin
			busy_cnt_r <= '0;
		end
	end
	property p_rel; cs_b [*5] |-> !so_oe; endproperty
	a_rel: assert property (p_rel) else $error("output driven deselected");
	property p_stby; cs_b [*5] ##0 !busy |-> standby; endproperty
	a_stby: assert property (p_stby) else $error("no standby");
	property p_awake; !cs_b [*5] |-> !standby; endproperty
	a_awake: assert property (p_awake) else $error("standby while selected");
	property p_pause; !hold_b [*5] |-> !so_oe; endproperty
	a_pause: assert property (p_pause) else $error("output driven in pause");
	property p_oe; so_oe |-> !$past(cs_b, 3); endproperty
	a_oe: assert property (p_oe) else $error("output outside session");
	property p_commit; mem_req_o.commit |-> cs_b && $past(cs_b, 2) ##1 busy; endproperty
	a_commit: assert property (p_commit) else $error("bad write cycle start");
	property p_wc; $fell(busy) |-> int'(busy_cnt_r) >= WC_CYCLES - 1; endproperty
	a_wc: assert property (p_wc) else $error("write cycle short");
	property p_wcmax; busy |-> int'(busy_cnt_r) <= WC_CYCLES + 1; endproperty
	a_wcmax: assert property (p_wcmax) else $error("write cycle long");
	property p_lend; $fell(busy) |-> !status_o[SB_LATCH]; endproperty
	a_lend: assert property (p_lend) else $error("latch kept after cycle");
	property p_wrl; mem_req_o.wr |-> status_o[SB_LATCH]; endproperty
	a_wrl: assert property (p_wrl) else $error("load without latch");
	property p_quiet; busy |-> !mem_req_o.wr && !mem_req_o.rd; endproperty
	a_quiet: assert property (p_quiet) else $error("access while busy");
endmodule : secp_top_assertions
bind secp_top secp_top_assertions #(.WC_CYCLES(WC_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b),
	.sck(sck), .cs_b(cs_b), .si(si), .wp_b(wp_b), .hold_b(hold_b), .so_o(so_o),
	.so_oe(so_oe), .standby(standby), .status_o(status_o), .mem_req_o(mem_req_o),
	.mem_rd_data(mem_rd_data));

// ### sim/secp_host_model.sv
// host bus controller model driving the serial pins
`timescale 1ns/1ps
module secp_host_model (
	input wire logic clk,
	input wire logic so_o,
	input wire logic so_oe,
	output logic sck,
	output logic cs_b,
	output logic si,
	output logic hold_b
);
	bit cpol = 1'b0;
	// clock idles at cpol, pause unused stays high
	initial begin
		sck = 1'b0;
		cs_b = 1'b1;
		si = 1'b0;
		hold_b = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic open_s();
		tick(1);
		sck = cpol;
		tick(2);
		cs_b = 1'b0;
		tick(4);
	endtask : open_s
	// msb first, set while sck low
	task automatic xbyte(input logic [7:0] tx, input bit pz, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			tick(4);
			if (pz && i == 3) begin
				hold_b = 1'b0;
				tick(12);
				hold_b = 1'b1;
				tick(4);
			end
			sck = 1'b1;
			tick(4);
			// released line reads as the inverse, so stale bits cannot pass
			rx[i] = so_oe ? so_o : ~so_o;
		end
	endtask : xbyte
	// select rises; released data line not left at its last level
	task automatic close_s();
		sck = cpol;
		tick(4);
		cs_b = 1'b1;
		si = ~si;
		tick(8);
	endtask : close_s
endmodule : secp_host_model

// ### sim/secp_top_tb.sv
// self-checking bench for the command port
`timescale 1ns/1ps
module secp_top_tb;
	import secp_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp_b = 1'b1;
	logic [7:0] mem_rd_data;
	logic sck, cs_b, si, hold_b, so_o, so_oe, standby;
	logic [7:0] status_o;
	logic [7:0] rxb [4];
	logic [7:0] rx;
	secp_mem_req_t mem_req_o;
	secp_mem_req_t last_wr;
	int error_cnt = 0;
	int n_tests = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	always #12.5 clk = ~clk;
	secp_top #(.WC_CYCLES(400)) uut (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
		.si(si), .wp_b(wp_b), .hold_b(hold_b), .so_o(so_o), .so_oe(so_oe),
		.standby(standby), .status_o(status_o), .mem_req_o(mem_req_o),
		.mem_rd_data(mem_rd_data));
	secp_host_model host (.clk(clk), .so_o(so_o), .so_oe(so_oe), .sck(sck), .cs_b(cs_b),
		.si(si), .hold_b(hold_b));
	// array stand-in: port samples data as the read pulse ends, so no register here
	assign mem_rd_data = mem_req_o.addr[7:0] ^ 8'h5A;
	always @(posedge clk) begin
		if (mem_req_o.rd === 1'b1) begin
			rd_cnt++;
		end
		if (mem_req_o.wr === 1'b1) begin
			wr_cnt++;
			last_wr = mem_req_o;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic sess(input logic [7:0] op, input int n, input logic [31:0] a, input bit pz);
		host.open_s();
		host.xbyte(op, 1'b0, rx);
		for (int k = 0; k < n; k++) begin
			host.xbyte(a[31-8*k -: 8], pz && k == n - 1, rxb[k]);
		end
		host.close_s();
	endtask : sess
	task automatic wait_idle();
		for (int k = 0; k < 600 && status_o[SB_BUSY] !== 1'b0; k++) begin
			@(posedge clk);
		end
		#1;
	endtask : wait_idle
	task automatic stat_wr(input logic [7:0] v);
		sess(OP_SET_LATCH, 0, 32'h0, 1'b0);
		sess(OP_STAT_WR, 1, {v, 24'h0}, 1'b0);
		wait_idle();
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
	endtask : stat_wr
	task automatic results();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (5) @(posedge clk);
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], STAT_RST);
		sess(8'h86, 0, 32'h0, 1'b0);
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], 8'h00);
		sess(OP_MEM_WR, 3, 32'h0010_1100, 1'b0);
		wait_idle();
		chk(8'(wr_cnt), 8'h00);
		sess(OP_SET_LATCH, 0, 32'h0, 1'b0);
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], 8'h02);
		sess(OP_CLR_LATCH, 0, 32'h0, 1'b0);
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], 8'h00);
		sess(OP_SET_LATCH, 0, 32'h0, 1'b0);
		host.cpol = 1'b1;
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], 8'h02);
		host.cpol = 1'b0;
		sess(OP_MEM_WR, 3, 32'h803F_3C00, 1'b0);
		chk(8'(wr_cnt), 8'h01);
		chk({1'b0, last_wr.addr[14:8]}, 8'h00);
		chk(last_wr.addr[7:0], 8'h3F);
		chk(last_wr.data, 8'h3C);
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], STAT_BUSY_BYTE);
		sess(OP_SET_LATCH, 0, 32'h0, 1'b0);
		sess(OP_MEM_RD, 3, 32'h0001_0000, 1'b0);
		chk(8'(rd_cnt), 8'h00);
		wait_idle();
		sess(OP_STAT_RD, 1, 32'h0, 1'b0);
		chk(rxb[0], 8'h00);
		stat_wr(8'h80);
		chk(rxb[0], 8'h80);
		wp_b = 1'b0;
		stat_wr(8'h8C);
		chk(rxb[0] & STAT_WR_MASK, 8'h80);
		wp_b = 1'b1;
		stat_wr(8'h0C);
		chk(rxb[0], 8'h0C);
		sess(OP_MEM_RD, 4, 32'h8123_0000, 1'b1);
		chk(rxb[2], 8'h23 ^ 8'h5A);
		chk(rxb[3], 8'h24 ^ 8'h5A);
		results();
	end
endmodule : secp_top_tb
